// ==== logic/pin_ctrl.sv ====
// Purpose: reset, strobe, address/data pin control and interrupt edge capture
// Assumes: chip_reset_input and interrupt pins are asynchronous, active low
// Notes:   one external access per clock; table ops sequence their fetches
`timescale 1ns/1ns
`default_nettype none
module pin_ctrl #(
  parameter int ADDR_W = pin_ctrl_pkg::ADDR_W,
  parameter int DATA_W = pin_ctrl_pkg::DATA_W
) (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    chipResetInputN,
  input  wire logic                    maskIntN,
  input  wire logic                    nmiN,
  input  wire logic                    maskIntAck,
  input  wire logic                    nmiAck,
  input  wire pin_ctrl_pkg::table_req_s tableReq,
  input  wire logic [DATA_W-1:0]       dataBusIn,
  output logic                         tableReqReady,
  output logic                         maskIntPending,
  output logic                         nmiPending,
  output logic                         coreRunning,
  output logic [ADDR_W-1:0]            programCounter,
  output logic [DATA_W-1:0]            fetchedWord,
  output logic                         fetchedValid,
  output logic [DATA_W-1:0]            tableReadData,
  output logic                         tableReadValid,
  output logic                         coreClockOutput,
  output pin_ctrl_pkg::bus_pins_s      busPins
);

  pin_ctrl_pkg::bus_state_e state;
  pin_ctrl_pkg::bus_state_e next_state;
  pin_ctrl_pkg::table_req_s heldReq;

  logic resetLevel;
  logic resetFall;
  logic maskIntFall;
  logic nmiFall;
  logic chipInReset;

  // reset pin synchronised before anything looks at it
  edge_sync u_reset_sync (
    .clk       (clk),
    .reset     (reset),
    .pinIn     (chipResetInputN),
    .level     (resetLevel),
    .fallPulse (resetFall)
  );

  edge_sync u_int_sync (
    .clk       (clk),
    .reset     (reset),
    .pinIn     (maskIntN),
    .level     (),
    .fallPulse (maskIntFall)
  );

  edge_sync u_nmi_sync (
    .clk       (clk),
    .reset     (reset),
    .pinIn     (nmiN),
    .level     (),
    .fallPulse (nmiFall)
  );

  assign chipInReset     = ~resetLevel;
  assign coreClockOutput = clk;
  assign tableReqReady   = (state == pin_ctrl_pkg::ST_FETCH) & ~chipInReset;

  // reset and bus sequencing
  always_comb begin
    next_state = state;
    case (state)
      pin_ctrl_pkg::ST_RESET: begin
        next_state = pin_ctrl_pkg::ST_FLOAT;
      end
      pin_ctrl_pkg::ST_FLOAT: begin
        next_state = pin_ctrl_pkg::ST_CLEAR;
      end
      pin_ctrl_pkg::ST_CLEAR: begin
        if (!chipInReset) begin
          next_state = pin_ctrl_pkg::ST_WAKE;
        end
      end
      pin_ctrl_pkg::ST_WAKE: begin
        next_state = pin_ctrl_pkg::ST_FETCH;
      end
      pin_ctrl_pkg::ST_FETCH: begin
        if (tableReq.valid && (tableReq.isRead || tableReq.isWrite)) begin
          next_state = pin_ctrl_pkg::ST_DUMMY;
        end
      end
      pin_ctrl_pkg::ST_DUMMY: begin
        next_state = heldReq.isRead ? pin_ctrl_pkg::ST_TDATA
                                    : pin_ctrl_pkg::ST_TWRITE;
      end
      pin_ctrl_pkg::ST_TDATA: begin
        next_state = pin_ctrl_pkg::ST_FETCH;
      end
      pin_ctrl_pkg::ST_TWRITE: begin
        next_state = pin_ctrl_pkg::ST_FETCH;
      end
      default: begin
        next_state = pin_ctrl_pkg::ST_RESET;
      end
    endcase
    if (resetFall) begin
      next_state = pin_ctrl_pkg::ST_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= pin_ctrl_pkg::ST_CLEAR;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      heldReq <= '0;
    end else if (state == pin_ctrl_pkg::ST_FETCH && tableReq.valid) begin
      heldReq <= tableReq;
    end
  end

  // program counter
  always_ff @(posedge clk) begin
    if (reset) begin
      programCounter <= pin_ctrl_pkg::PC_RESET_VALUE;
    end else if (state == pin_ctrl_pkg::ST_FLOAT || state == pin_ctrl_pkg::ST_CLEAR) begin
      programCounter <= pin_ctrl_pkg::PC_RESET_VALUE;
    end else if (next_state == pin_ctrl_pkg::ST_FETCH) begin
      // advance on the edge that puts this address on the pins; the ST_FETCH after a table op rereads the ST_DUMMY address
      programCounter <= programCounter + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      coreRunning <= 1'b0;
    end else begin
      coreRunning <= (next_state == pin_ctrl_pkg::ST_FETCH)
                     || (next_state == pin_ctrl_pkg::ST_DUMMY)
                     || (next_state == pin_ctrl_pkg::ST_TDATA)
                     || (next_state == pin_ctrl_pkg::ST_TWRITE);
    end
  end

  // pin drive
  always_ff @(posedge clk) begin
    if (reset) begin
      busPins <= '{readStrobeN: 1'b1, writeStrobeN: 1'b1, strobeOe: 1'b0,
                   addr: '0, addrOe: 1'b0, dataOut: '0, dataOe: 1'b0};
    end else begin
      case (next_state)
        pin_ctrl_pkg::ST_RESET: begin
          busPins.readStrobeN  <= 1'b1;
          busPins.writeStrobeN <= 1'b1;
          busPins.strobeOe     <= 1'b1;
          busPins.dataOe       <= 1'b0;
        end
        pin_ctrl_pkg::ST_FLOAT, pin_ctrl_pkg::ST_CLEAR, pin_ctrl_pkg::ST_WAKE: begin
          busPins.readStrobeN  <= 1'b1;
          busPins.writeStrobeN <= 1'b1;
          busPins.strobeOe     <= 1'b0;
          busPins.addrOe       <= 1'b0;
          busPins.dataOe       <= 1'b0;
          if (state != pin_ctrl_pkg::ST_RESET) begin
            busPins.addr <= '0;
          end
        end
        pin_ctrl_pkg::ST_TDATA: begin
          busPins.readStrobeN  <= 1'b0;
          busPins.writeStrobeN <= 1'b1;
          busPins.strobeOe     <= 1'b1;
          busPins.addr         <= heldReq.tableAddr;
          busPins.addrOe       <= 1'b1;
          busPins.dataOe       <= 1'b0;
        end
        pin_ctrl_pkg::ST_TWRITE: begin
          busPins.readStrobeN  <= 1'b1;
          busPins.writeStrobeN <= 1'b0;
          busPins.strobeOe     <= 1'b1;
          busPins.addr         <= heldReq.tableAddr;
          busPins.addrOe       <= 1'b1;
          busPins.dataOut      <= heldReq.writeData;
          busPins.dataOe       <= 1'b1;
        end
        default: begin
          // instruction prefetch or dummy prefetch
          busPins.readStrobeN  <= 1'b0;
          busPins.writeStrobeN <= 1'b1;
          busPins.strobeOe     <= 1'b1;
          busPins.addr         <= (next_state == pin_ctrl_pkg::ST_FETCH
                                   && (state == pin_ctrl_pkg::ST_WAKE))
                                  ? pin_ctrl_pkg::PC_RESET_VALUE : programCounter;
          busPins.addrOe       <= 1'b1;
          busPins.dataOe       <= 1'b0;
        end
      endcase
    end
  end

  // captured read data
  always_ff @(posedge clk) begin
    if (reset) begin
      fetchedWord    <= '0;
      fetchedValid   <= 1'b0;
      tableReadData  <= '0;
      tableReadValid <= 1'b0;
    end else begin
      fetchedValid   <= 1'b0;
      tableReadValid <= 1'b0;
      if (state == pin_ctrl_pkg::ST_FETCH || state == pin_ctrl_pkg::ST_DUMMY) begin
        fetchedWord  <= dataBusIn;
        fetchedValid <= 1'b1;
      end
      if (state == pin_ctrl_pkg::ST_TDATA) begin
        tableReadData  <= dataBusIn;
        tableReadValid <= 1'b1;
      end
    end
  end

  // interrupt pending flags: a new edge wins over the acknowledge
  always_ff @(posedge clk) begin
    if (reset || chipInReset) begin
      maskIntPending <= 1'b0;
    end else if (maskIntFall) begin
      maskIntPending <= 1'b1;
    end else if (maskIntAck) begin
      maskIntPending <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || chipInReset) begin
      nmiPending <= 1'b0;
    end else if (nmiFall) begin
      nmiPending <= 1'b1;
    end else if (nmiAck) begin
      nmiPending <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ==== logic/pin_ctrl_pkg.sv ====
// Purpose: shared constants and carriers for the external pin controller
// Assumes: single 25 MHz clock domain
// Notes:   bus cycles are one clock long in this model
package pin_ctrl_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;

  // reset pin must stay low this many cycles (other party keeps it)
  localparam int RESET_MIN_CYCLES = 5;

  localparam logic [ADDR_W-1:0] PC_RESET_VALUE = 12'h000;

  typedef enum logic [2:0] {
    ST_RESET  = 3'h0,
    ST_FLOAT  = 3'h1,
    ST_CLEAR  = 3'h2,
    ST_WAKE   = 3'h3,
    ST_FETCH  = 3'h4,
    ST_DUMMY  = 3'h5,
    ST_TDATA  = 3'h6,
    ST_TWRITE = 3'h7
  } bus_state_e;

  typedef struct packed {
    logic              readStrobeN;
    logic              writeStrobeN;
    logic              strobeOe;
    logic [ADDR_W-1:0] addr;
    logic              addrOe;
    logic [DATA_W-1:0] dataOut;
    logic              dataOe;
  } bus_pins_s;

  typedef struct packed {
    logic              valid;
    logic              isRead;
    logic              isWrite;
    logic [ADDR_W-1:0] tableAddr;
    logic [DATA_W-1:0] writeData;
  } table_req_s;

endpackage

// ==== logic/edge_sync.sv ====
// Purpose: two-flop synchroniser with falling-edge pulse
// Assumes: input is asynchronous to clk
// Notes:   first flop feeds only the second
`timescale 1ns/1ns
`default_nettype none
module edge_sync (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic pinIn,
  output logic      level,
  output logic      fallPulse
);

  logic meta;
  logic prev;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta  <= 1'b1;
      level <= 1'b1;
    end else begin
      meta  <= pinIn;
      level <= meta;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prev <= 1'b1;
    end else begin
      prev <= level;
    end
  end

  // one pulse on high-to-low only; a held low gives nothing more
  assign fallPulse = prev & ~level;

endmodule
`default_nettype wire

// ==== testbench/pin_ctrl_props.sv ====
// Purpose: checker for the pin controller ports
// Assumes: one clock, sync active-high reset
// Notes:   bound to pin_ctrl below
`timescale 1ns/1ns
`default_nettype none
module pin_ctrl_props #(
  parameter int ADDR_W = pin_ctrl_pkg::ADDR_W
) (
  input wire logic                     clk,
  input wire logic                     reset,
  input wire logic                     chipResetInputN,
  input wire logic                     maskIntN,
  input wire logic                     maskIntAck,
  input wire pin_ctrl_pkg::table_req_s tableReq,
  input wire logic                     tableReqReady,
  input wire logic                     maskIntPending,
  input wire logic                     nmiPending,
  input wire logic                     coreRunning,
  input wire logic [ADDR_W-1:0]        programCounter,
  input wire logic                     tableReadValid,
  input wire pin_ctrl_pkg::bus_pins_s  busPins
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic take;
  assign take = tableReqReady && tableReq.valid;

  a_strobe_exclusive: assert property (
    busPins.strobeOe |-> busPins.readStrobeN || busPins.writeStrobeN) else $error("both strobes");
  a_reset_float_order: assert property ($fell(chipResetInputN) |-> ##[1:4]
    (busPins.strobeOe && busPins.readStrobeN && busPins.writeStrobeN && !busPins.dataOe)
    ##1 (!busPins.strobeOe && !busPins.addrOe)) else $error("reset float order");
  a_addr_clear: assert property (
    $fell(busPins.strobeOe) |=> busPins.addr == '0 && programCounter == '0)
    else $error("address not cleared");
  a_resume_fetch: assert property ($rose(chipResetInputN) |-> !coreRunning ##[2:5]
    (coreRunning && !busPins.readStrobeN && busPins.addr == '0)) else $error("no resume");
  a_int_edge: assert property (
    $fell(maskIntN) |-> ##[2:4] maskIntPending) else $error("edge missed");
  a_int_level: assert property (maskIntAck && !maskIntN && $past(maskIntN) == 1'b0 &&
    $past(maskIntN, 2) == 1'b0 && $past(maskIntN, 3) == 1'b0 |=> !maskIntPending)
    else $error("level retriggered");
  a_table_read: assert property (take && tableReq.isRead |=> !busPins.readStrobeN ##1
    (!busPins.readStrobeN && busPins.addr == $past(tableReq.tableAddr, 2)) ##1 tableReadValid)
    else $error("table read order");
  a_table_write: assert property (take && tableReq.isWrite && !tableReq.isRead |-> ##2
    (!busPins.writeStrobeN && busPins.dataOe && busPins.dataOut == $past(tableReq.writeData, 2)))
    else $error("table write");
  cover property (tableReadValid);
  cover property (maskIntPending && nmiPending);
  cover property ($rose(coreRunning));
endmodule
bind pin_ctrl pin_ctrl_props #(.ADDR_W(ADDR_W)) i_pin_ctrl_props (.clk, .reset,
  .chipResetInputN, .maskIntN, .maskIntAck, .tableReq, .tableReqReady, .maskIntPending,
  .nmiPending, .coreRunning, .programCounter, .tableReadValid, .busPins);
`default_nettype wire

// ==== testbench/ext_mem_model.sv ====
// Purpose: external memory on the data bus
// Assumes: word at an address is {4'hd, address}
// Notes:   bus shows a changing pattern when not read
`timescale 1ns/1ns
`default_nettype none
module ext_mem_model (
  input  wire logic                       clk,
  input  wire pin_ctrl_pkg::bus_pins_s    busPins,
  output logic [pin_ctrl_pkg::DATA_W-1:0] dataBusIn
);
  logic [15:0] noise = 16'h5a5a;
  always @(posedge clk) noise <= ~noise;
  assign dataBusIn = (busPins.strobeOe && !busPins.readStrobeN) ? {4'hd, busPins.addr} : noise;
endmodule
`default_nettype wire

// ==== testbench/dsp_reset_and_interrupt_pins_test.sv ====
// Purpose: testbench for the pin controller
// Assumes: 25 MHz clock
// Notes:   table reads checked through a queue
`timescale 1ns/1ns
`default_nettype none
module dsp_reset_and_interrupt_pins_test;
  logic clk, reset, chipResetInputN, maskIntN, nmiN, maskIntAck, nmiAck;
  logic tableReqReady, maskIntPending, nmiPending, coreRunning, fetchedValid, tableReadValid;
  logic coreClkOut;
  logic [15:0] dataBusIn, tableReadData, fetchedWord, expQ[$];
  logic [11:0] programCounter;
  logic [31:0] rnd = 32'h39;
  pin_ctrl_pkg::table_req_s tableReq;
  pin_ctrl_pkg::bus_pins_s  busPins;
  int n_fail = 0, checks = 0, i;

  pin_ctrl i_pin_ctrl (.clk, .reset, .chipResetInputN, .maskIntN, .nmiN, .maskIntAck, .nmiAck,
    .tableReq, .dataBusIn, .tableReqReady, .maskIntPending, .nmiPending, .coreRunning,
    .programCounter, .fetchedWord, .fetchedValid, .tableReadData, .tableReadValid,
    .coreClockOutput(coreClkOut), .busPins);
  ext_mem_model i_ext_mem_model (.clk, .busPins, .dataBusIn);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic tbl(input logic rd, input logic wr, input logic [11:0] a, input logic [15:0] d);
    tableReq = '{1'b1, rd, wr, a, d};
    for (int k = 0; k < 20 && tableReqReady !== 1'b1; k++) step(1);
    if (rd) expQ.push_back({4'hd, a});
    step(1);
    tableReq.valid = 1'b0;
    step(1);
    chk({4'h0, busPins.addr}, {4'h0, a});
    chk({14'h0, busPins.readStrobeN, busPins.writeStrobeN}, {14'h0, !rd, rd});
    if (wr && !rd) chk(busPins.dataOut, d);
    step(2);
  endtask

  task automatic report_and_stop;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(negedge clk) begin
    if (tableReadValid === 1'b1) chk(tableReadData, expQ.size() ? expQ.pop_front() : 16'hx);
  end

  initial begin
    #400000;
    n_fail++;
    report_and_stop;
  end

  initial begin
    reset = 1'b1;
    {chipResetInputN, maskIntN, nmiN, maskIntAck, nmiAck} = 5'h1c;
    tableReq = '0;
    step(12);
    reset = 1'b0;
    step(3);
    chk({15'h0, coreRunning}, 16'h1);
    chk({15'h0, fetchedValid}, 16'h1);
    chk(fetchedWord, 16'hd000);
    chk({15'h0, coreClkOut}, 16'h1);
    for (i = 0; i < 9; i++) begin
      rnd = xs(rnd);
      tbl(i % 3 != 1, i % 3 != 0, rnd[13:2], rnd[31:16]);
    end
    tbl(1'b1, 1'b0, 12'hfff, 16'h0);
    for (i = 0; i < 3; i++) begin
      maskIntN = i == 1;
      nmiN = i == 0;
      step(4);
      chk({14'h0, maskIntPending, nmiPending}, {14'h0, i != 1, i != 0});
      {maskIntAck, nmiAck} = 2'h3;
      step(1);
      {maskIntAck, nmiAck} = 2'h0;
      step(3);
      chk({14'h0, maskIntPending, nmiPending}, 16'h0);
      {maskIntN, nmiN} = 2'h3;
      step(3);
    end
    chipResetInputN = 1'b0;
    step(7);
    chk({busPins.strobeOe, busPins.addrOe, busPins.dataOe, coreRunning, busPins.addr}, 16'h0);
    chk({4'h0, programCounter}, 16'h0);
    step(1);
    chipResetInputN = 1'b1;
    for (i = 0; i < 10 && coreRunning !== 1'b1; i++) step(1);
    chk({15'h0, i inside {[3:5]}}, 16'h1);
    chk({4'h0, busPins.addr}, 16'h0);
    tbl(1'b1, 1'b0, 12'h001, 16'h0);
    step(5);
    chk(16'(expQ.size()), 16'h0);
    report_and_stop;
  end
endmodule
`default_nettype wire
